/* File: common/mid_pkg.sv */
// shared constants and types for the instruction datapath
package mid_pkg;
  localparam int SECT_W     = 2;
  localparam int OFS_W      = 8;
  localparam int DM_ADDR_W  = SECT_W + OFS_W;
  localparam int PROG_W     = 16;
  localparam int REG_ADDR_W = 3;
  localparam int FLG_W      = 5;

  // register offsets
  localparam logic [REG_ADDR_W-1:0] REG_ACC     = 3'h0;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS  = 3'h1;
  localparam logic [REG_ADDR_W-1:0] REG_TPTR_LO = 3'h2;
  localparam logic [REG_ADDR_W-1:0] REG_TPTR_HI = 3'h3;
  localparam logic [REG_ADDR_W-1:0] REG_THIGH   = 3'h4;
  localparam logic [REG_ADDR_W-1:0] REG_SECT    = 3'h5;
  localparam logic [REG_ADDR_W-1:0] REG_DM_PTR  = 3'h6;
  localparam logic [REG_ADDR_W-1:0] REG_DM_DATA = 3'h7;

  // status field positions
  localparam int FLG_C    = 0;
  localparam int FLG_HALF = 1;
  localparam int FLG_Z    = 2;
  localparam int FLG_WRAP = 3;
  localparam int FLG_SC   = 4;

  // reset values
  localparam logic [7:0]        ACC_RST   = 8'h00;
  localparam logic [FLG_W-1:0]  FLAGS_RST = 5'h00;
  localparam logic [7:0]        TPTR_RST  = 8'h00;
  localparam logic [7:0]        THIGH_RST = 8'h00;
  localparam logic [SECT_W-1:0] SECT_RST  = 2'h0;
  localparam logic [7:0]        DPTR_RST  = 8'h00;

  // decimal adjust constants
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_ADJ   = 4'h6;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_NIBBLE_SWAP_TO_ACC = 5'h01,
    OP_SKIP_IF_ZERO = 5'h02, OP_SKIP_IF_ZERO_LOAD_ACC = 5'h03,
    OP_SKIP_IF_ZERO_BIT = 5'h04, OP_TABLE_READ_PAGED = 5'h05,
    OP_TABLE_READ_LAST_PAGE = 5'h06, OP_TABLE_READ_PREINC = 5'h07,
    OP_TABLE_READ_LAST_PREINC = 5'h08, OP_XOR_TO_ACC = 5'h09,
    OP_XOR_TO_MEMORY = 5'h0A, OP_XOR_IMM = 5'h0B,
    OP_EXT_ADD_CARRY = 5'h0C, OP_EXT_ADD_CARRY_TO_MEM = 5'h0D,
    OP_EXT_ADD = 5'h0E, OP_EXT_ADD_TO_MEM = 5'h0F,
    OP_EXT_AND = 5'h10, OP_EXT_AND_TO_MEM = 5'h11,
    OP_EXT_CLEAR = 5'h12, OP_EXT_CLEAR_BIT = 5'h13,
    OP_EXT_INVERT = 5'h14, OP_EXT_INVERT_TO_ACC = 5'h15,
    OP_EXT_DECIMAL_ADJUST = 5'h16, OP_EXT_DECREMENT = 5'h17,
    OP_EXT_DECREMENT_TO_ACC = 5'h18, OP_EXT_INCREMENT = 5'h19,
    OP_EXT_INCREMENT_TO_ACC = 5'h1A, OP_EXT_MOVE = 5'h1B,
    OP_EXT_MOVE_TO_MEM = 5'h1C
  } mid_op_e;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_TBL_REQ  = 2'b01,
    ST_TBL_DATA = 2'b10,
    ST_DUMMY    = 2'b11
  } mid_state_e;

  typedef struct packed {
    mid_op_e              op;
    logic [2:0]           bit_sel;
    logic [DM_ADDR_W-1:0] addr;
    logic [7:0]           imm;
  } mid_cmd_s;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [REG_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
  } mid_reg_req_s;
endpackage

/* File: rtl/mid_datapath.sv */
// instruction execution datapath: swap, skips, table reads, xor, extended ops
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module mid_datapath #(
  parameter int PROG_ADDR_W = 12
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  input  wire logic                           cmd_valid,
  input  wire mid_pkg::mid_cmd_s              cmd,
  input  wire logic [mid_pkg::PROG_W-1:0]     prog_rdata,
  input  wire mid_pkg::mid_reg_req_s          reg_req,
  output logic                                busy_ff,
  output logic                                done_ff,
  output logic                                skip_ff,
  output logic [7:0]                          acc_ff,
  output logic [mid_pkg::FLG_W-1:0]           flags_ff,
  output logic [PROG_ADDR_W-1:0]              prog_addr_ff,
  output logic                                prog_rd_ff,
  output logic [7:0]                          reg_rdata_ff
);
  localparam int DM_DEPTH = 1 << mid_pkg::DM_ADDR_W;

  if (PROG_ADDR_W < 9 || PROG_ADDR_W > 16) begin : g_bad_prog_addr_w
    $error("PROG_ADDR_W must lie in 9..16");
  end

  logic                           rst_meta_b_ff;
  logic                           rst_sync_b_ff;
  mid_pkg::mid_state_e            st_ff;
  mid_pkg::mid_state_e            nxt_st;
  logic [7:0]                     dmem [DM_DEPTH];
  logic [7:0]                     tptr_lo_ff;
  logic [7:0]                     tptr_hi_ff;
  logic [7:0]                     thigh_ff;
  logic [mid_pkg::SECT_W-1:0]     sect_ff;
  logic [7:0]                     dptr_ff;
  logic [mid_pkg::DM_ADDR_W-1:0]  tbl_dst_ff;
  logic                           take;
  logic                           is_ext;
  logic [mid_pkg::DM_ADDR_W-1:0]  eaddr;
  logic [mid_pkg::DM_ADDR_W-1:0]  sw_addr;
  logic [7:0]                     mdat;
  logic [7:0]                     res;
  logic                           to_acc;
  logic                           to_mem;
  logic                           set_z;
  logic                           set_arith;
  logic                           set_c_only;
  logic                           skip_now;
  logic                           tbl_op;
  logic                           tbl_inc;
  logic                           tbl_last;
  logic                           cin;
  logic [8:0]                     sum9;
  logic [4:0]                     lo5;
  logic                           ovf;
  logic                           lo_adj;
  logic                           hi_adj;
  logic [8:0]                     daa9;
  logic [7:0]                     ptr_lo;
  logic [15:0]                    paged_addr;
  logic                           sw_wr_dm;
  logic                           tbl_wr;

  default clocking cb_dp @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_b_ff);

  // reset release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b_ff <= 1'b0;
      rst_sync_b_ff <= 1'b0;
    end else begin
      rst_meta_b_ff <= 1'b1;
      rst_sync_b_ff <= rst_meta_b_ff;
    end
  end

  assign take = cmd_valid && (st_ff == mid_pkg::ST_IDLE);
  assign is_ext = (cmd.op >= mid_pkg::OP_EXT_ADD_CARRY);
  // extended ops take the full address, others the selected section
  assign eaddr = is_ext ? cmd.addr :
                 {sect_ff, cmd.addr[mid_pkg::OFS_W-1:0]};
  assign sw_addr = {sect_ff, dptr_ff};
  assign mdat = dmem[eaddr];
  assign sw_wr_dm = reg_req.wr && (reg_req.addr == mid_pkg::REG_DM_DATA);
  assign tbl_wr = (st_ff == mid_pkg::ST_TBL_DATA);

  // arithmetic
  always_comb begin
    cin = (cmd.op == mid_pkg::OP_EXT_ADD_CARRY ||
           cmd.op == mid_pkg::OP_EXT_ADD_CARRY_TO_MEM) ?
          flags_ff[mid_pkg::FLG_C] : 1'b0;
    sum9 = {1'b0, acc_ff} + {1'b0, mdat} + {8'h00, cin};
    lo5 = {1'b0, acc_ff[3:0]} + {1'b0, mdat[3:0]} + {4'h0, cin};
    ovf = (acc_ff[7] == mdat[7]) && (sum9[7] != acc_ff[7]);
    lo_adj = (acc_ff[3:0] > mid_pkg::BCD_LIMIT) ||
             flags_ff[mid_pkg::FLG_HALF];
    hi_adj = (acc_ff[7:4] > mid_pkg::BCD_LIMIT) ||
             flags_ff[mid_pkg::FLG_C];
    daa9 = {1'b0, acc_ff} + {1'b0, (hi_adj ? mid_pkg::BCD_ADJ : 4'h0),
                             (lo_adj ? mid_pkg::BCD_ADJ : 4'h0)};
  end

  // operation decode
  always_comb begin
    res = 8'h00;
    to_acc = 1'b0;
    to_mem = 1'b0;
    set_z = 1'b0;
    set_arith = 1'b0;
    set_c_only = 1'b0;
    skip_now = 1'b0;
    tbl_op = 1'b0;
    tbl_inc = 1'b0;
    tbl_last = 1'b0;
    case (cmd.op)
      mid_pkg::OP_NIBBLE_SWAP_TO_ACC: begin
        res = {mdat[3:0], mdat[7:4]};
        to_acc = 1'b1;
      end
      mid_pkg::OP_SKIP_IF_ZERO: begin
        skip_now = (mdat == 8'h00);
      end
      mid_pkg::OP_SKIP_IF_ZERO_LOAD_ACC: begin
        res = mdat;
        to_acc = 1'b1;
        skip_now = (mdat == 8'h00);
      end
      mid_pkg::OP_SKIP_IF_ZERO_BIT: begin
        skip_now = !mdat[cmd.bit_sel];
      end
      mid_pkg::OP_TABLE_READ_PAGED: begin
        tbl_op = 1'b1;
      end
      mid_pkg::OP_TABLE_READ_LAST_PAGE: begin
        tbl_op = 1'b1;
        tbl_last = 1'b1;
      end
      mid_pkg::OP_TABLE_READ_PREINC: begin
        tbl_op = 1'b1;
        tbl_inc = 1'b1;
      end
      mid_pkg::OP_TABLE_READ_LAST_PREINC: begin
        tbl_op = 1'b1;
        tbl_inc = 1'b1;
        tbl_last = 1'b1;
      end
      mid_pkg::OP_XOR_TO_ACC, mid_pkg::OP_XOR_TO_MEMORY: begin
        res = acc_ff ^ mdat;
        to_acc = (cmd.op == mid_pkg::OP_XOR_TO_ACC);
        to_mem = (cmd.op == mid_pkg::OP_XOR_TO_MEMORY);
        set_z = 1'b1;
      end
      mid_pkg::OP_XOR_IMM: begin
        res = acc_ff ^ cmd.imm;
        to_acc = 1'b1;
        set_z = 1'b1;
      end
      mid_pkg::OP_EXT_ADD_CARRY, mid_pkg::OP_EXT_ADD: begin
        res = sum9[7:0];
        to_acc = 1'b1;
        set_arith = 1'b1;
      end
      mid_pkg::OP_EXT_ADD_CARRY_TO_MEM, mid_pkg::OP_EXT_ADD_TO_MEM: begin
        res = sum9[7:0];
        to_mem = 1'b1;
        set_arith = 1'b1;
      end
      mid_pkg::OP_EXT_AND, mid_pkg::OP_EXT_AND_TO_MEM: begin
        res = acc_ff & mdat;
        to_acc = (cmd.op == mid_pkg::OP_EXT_AND);
        to_mem = (cmd.op == mid_pkg::OP_EXT_AND_TO_MEM);
        set_z = 1'b1;
      end
      mid_pkg::OP_EXT_CLEAR: begin
        res = 8'h00;
        to_mem = 1'b1;
      end
      mid_pkg::OP_EXT_CLEAR_BIT: begin
        res = mdat & ~(8'h01 << cmd.bit_sel);
        to_mem = 1'b1;
      end
      mid_pkg::OP_EXT_INVERT, mid_pkg::OP_EXT_INVERT_TO_ACC: begin
        res = ~mdat;
        to_acc = (cmd.op == mid_pkg::OP_EXT_INVERT_TO_ACC);
        to_mem = (cmd.op == mid_pkg::OP_EXT_INVERT);
        set_z = 1'b1;
      end
      mid_pkg::OP_EXT_DECIMAL_ADJUST: begin
        res = daa9[7:0];
        to_mem = 1'b1;
        set_c_only = 1'b1;
      end
      mid_pkg::OP_EXT_DECREMENT, mid_pkg::OP_EXT_DECREMENT_TO_ACC: begin
        res = mdat - 8'h01;
        to_acc = (cmd.op == mid_pkg::OP_EXT_DECREMENT_TO_ACC);
        to_mem = (cmd.op == mid_pkg::OP_EXT_DECREMENT);
        set_z = 1'b1;
      end
      mid_pkg::OP_EXT_INCREMENT, mid_pkg::OP_EXT_INCREMENT_TO_ACC: begin
        res = mdat + 8'h01;
        to_acc = (cmd.op == mid_pkg::OP_EXT_INCREMENT_TO_ACC);
        to_mem = (cmd.op == mid_pkg::OP_EXT_INCREMENT);
        set_z = 1'b1;
      end
      mid_pkg::OP_EXT_MOVE: begin
        res = mdat;
        to_acc = 1'b1;
      end
      mid_pkg::OP_EXT_MOVE_TO_MEM: begin
        res = acc_ff;
        to_mem = 1'b1;
      end
      default: begin
        res = 8'h00;
      end
    endcase
  end

  // table pointer low after optional pre-increment
  assign ptr_lo = tbl_inc ? (tptr_lo_ff + 8'h01) : tptr_lo_ff;
  assign paged_addr = {tptr_hi_ff, ptr_lo};

  // sequencing
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      mid_pkg::ST_IDLE: begin
        if (take && tbl_op) begin
          nxt_st = mid_pkg::ST_TBL_REQ;
        end else if (take && skip_now) begin
          nxt_st = mid_pkg::ST_DUMMY;
        end
      end
      mid_pkg::ST_TBL_REQ: begin
        nxt_st = mid_pkg::ST_TBL_DATA;
      end
      mid_pkg::ST_TBL_DATA: begin
        nxt_st = mid_pkg::ST_IDLE;
      end
      mid_pkg::ST_DUMMY: begin
        nxt_st = mid_pkg::ST_IDLE;
      end
      default: begin
        nxt_st = mid_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      st_ff <= mid_pkg::ST_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      skip_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      busy_ff <= (nxt_st != mid_pkg::ST_IDLE);
      done_ff <= (take && !tbl_op && !skip_now) ||
                 (st_ff == mid_pkg::ST_DUMMY) || tbl_wr;
      skip_ff <= take && skip_now;
    end
  end

  // accumulator
  always_ff @(posedge sys_clk or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      acc_ff <= mid_pkg::ACC_RST;
    end else if (take && to_acc) begin
      acc_ff <= res;
    end else if (reg_req.wr && reg_req.addr == mid_pkg::REG_ACC) begin
      acc_ff <= reg_req.wdata;
    end
  end

  // status flags, hardware update wins over software write
  always_ff @(posedge sys_clk or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      flags_ff <= mid_pkg::FLAGS_RST;
    end else if (take && set_arith) begin
      flags_ff[mid_pkg::FLG_C] <= sum9[8];
      flags_ff[mid_pkg::FLG_HALF] <= lo5[4];
      flags_ff[mid_pkg::FLG_Z] <= (res == 8'h00);
      flags_ff[mid_pkg::FLG_WRAP] <= ovf;
      flags_ff[mid_pkg::FLG_SC] <= ovf ^ res[7];
    end else if (take && set_z) begin
      flags_ff[mid_pkg::FLG_Z] <= (res == 8'h00);
    end else if (take && set_c_only) begin
      flags_ff[mid_pkg::FLG_C] <= hi_adj | daa9[8];
    end else if (take) begin
      flags_ff <= flags_ff;
    end else if (reg_req.wr && reg_req.addr == mid_pkg::REG_STATUS) begin
      flags_ff <= reg_req.wdata[mid_pkg::FLG_W-1:0];
    end
  end

  // data memory, instruction writes win over software writes
  always_ff @(posedge sys_clk) begin
    if (tbl_wr) begin
      dmem[tbl_dst_ff] <= prog_rdata[7:0];
    end else if (take && to_mem) begin
      dmem[eaddr] <= res;
    end else if (sw_wr_dm) begin
      dmem[sw_addr] <= reg_req.wdata;
    end
  end

  // table pointers and program fetch
  always_ff @(posedge sys_clk or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      tptr_lo_ff <= mid_pkg::TPTR_RST;
      tptr_hi_ff <= mid_pkg::TPTR_RST;
      prog_addr_ff <= '0;
      prog_rd_ff <= 1'b0;
      tbl_dst_ff <= '0;
    end else begin
      prog_rd_ff <= take && tbl_op;
      if (take && tbl_op) begin
        tptr_lo_ff <= ptr_lo;
        tbl_dst_ff <= eaddr;
        if (tbl_last) begin
          prog_addr_ff <= {{(PROG_ADDR_W-8){1'b1}}, ptr_lo};
        end else begin
          prog_addr_ff <= paged_addr[PROG_ADDR_W-1:0];
        end
      end else if (reg_req.wr) begin
        if (reg_req.addr == mid_pkg::REG_TPTR_LO) begin
          tptr_lo_ff <= reg_req.wdata;
        end
        if (reg_req.addr == mid_pkg::REG_TPTR_HI) begin
          tptr_hi_ff <= reg_req.wdata;
        end
      end
    end
  end

  // table high latch
  always_ff @(posedge sys_clk or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      thigh_ff <= mid_pkg::THIGH_RST;
    end else if (tbl_wr) begin
      thigh_ff <= prog_rdata[mid_pkg::PROG_W-1:8];
    end
  end

  // section select and software memory pointer
  always_ff @(posedge sys_clk or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      sect_ff <= mid_pkg::SECT_RST;
      dptr_ff <= mid_pkg::DPTR_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == mid_pkg::REG_SECT) begin
        sect_ff <= reg_req.wdata[mid_pkg::SECT_W-1:0];
      end
      if (reg_req.addr == mid_pkg::REG_DM_PTR) begin
        dptr_ff <= reg_req.wdata;
      end
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        mid_pkg::REG_ACC:     reg_rdata_ff <= acc_ff;
        mid_pkg::REG_STATUS:  reg_rdata_ff <= {3'h0, flags_ff};
        mid_pkg::REG_TPTR_LO: reg_rdata_ff <= tptr_lo_ff;
        mid_pkg::REG_TPTR_HI: reg_rdata_ff <= tptr_hi_ff;
        mid_pkg::REG_THIGH:   reg_rdata_ff <= thigh_ff;
        mid_pkg::REG_SECT:    reg_rdata_ff <= {6'h00, sect_ff};
        mid_pkg::REG_DM_PTR:  reg_rdata_ff <= dptr_ff;
        mid_pkg::REG_DM_DATA: reg_rdata_ff <= dmem[sw_addr];
        default:              reg_rdata_ff <= 8'h00;
      endcase
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  // capture of operands for checking
  logic                       take_q;
  mid_pkg::mid_op_e           op_q;
  logic [7:0]                 m_q;
  logic [7:0]                 acc_q;
  logic [mid_pkg::FLG_W-1:0]  flg_q;
  logic [2:0]                 bit_q;
  always_ff @(posedge sys_clk or negedge rst_sync_b_ff) begin
    if (!rst_sync_b_ff) begin
      take_q <= 1'b0;
      op_q <= mid_pkg::OP_NOP;
      m_q <= 8'h00;
      acc_q <= 8'h00;
      flg_q <= '0;
      bit_q <= 3'h0;
    end else begin
      take_q <= take;
      op_q <= cmd.op;
      m_q <= mdat;
      acc_q <= acc_ff;
      flg_q <= flags_ff;
      bit_q <= cmd.bit_sel;
    end
  end

  AST_SWAP: assert property (
    take_q && op_q == mid_pkg::OP_NIBBLE_SWAP_TO_ACC |->
    acc_ff == {m_q[3:0], m_q[7:4]} && flags_ff == flg_q)
    else $error("nibble swap result wrong");
  AST_SKIP_ZERO: assert property (
    take_q && op_q == mid_pkg::OP_SKIP_IF_ZERO |->
    skip_ff == (m_q == 8'h00) && flags_ff == flg_q)
    else $error("byte zero skip wrong");
  AST_SKIP_DUMMY: assert property (
    take && skip_now |=> busy_ff && !done_ff ##1 done_ff && !busy_ff)
    else $error("skip dummy cycle missing");
  AST_SKIP_LOAD: assert property (
    take_q && op_q == mid_pkg::OP_SKIP_IF_ZERO_LOAD_ACC |->
    acc_ff == m_q && skip_ff == (m_q == 8'h00))
    else $error("skip with load wrong");
  AST_SKIP_BIT: assert property (
    take_q && op_q == mid_pkg::OP_SKIP_IF_ZERO_BIT |-> skip_ff == !m_q[bit_q])
    else $error("bit skip wrong");
  AST_TBL_LATCH: assert property (
    take && tbl_op |=> prog_rd_ff ##1 !prog_rd_ff ##1
    done_ff && thigh_ff == $past(prog_rdata[15:8]))
    else $error("table high latch not loaded");
  AST_TBL_LAST: assert property (
    take && tbl_last |=> prog_addr_ff[PROG_ADDR_W-1:8] == '1)
    else $error("last page address wrong");
  AST_TBL_INC: assert property (
    take && tbl_inc |=> tptr_lo_ff == $past(tptr_lo_ff) + 8'h01 &&
    prog_addr_ff[7:0] == tptr_lo_ff)
    else $error("pointer pre-increment wrong");
  AST_XOR: assert property (
    take_q && op_q == mid_pkg::OP_XOR_TO_ACC |-> acc_ff == (acc_q ^ m_q) &&
    flags_ff[mid_pkg::FLG_C] == flg_q[mid_pkg::FLG_C])
    else $error("xor result or flags wrong");
  AST_ADD: assert property (
    take_q && op_q == mid_pkg::OP_EXT_ADD |->
    {flags_ff[mid_pkg::FLG_C], acc_ff} == {1'b0, acc_q} + {1'b0, m_q})
    else $error("add result wrong");
  AST_CLEAR: assert property (
    take_q && op_q == mid_pkg::OP_EXT_CLEAR |-> flags_ff == flg_q)
    else $error("clear changed a flag");
  AST_DAA: assert property (
    take_q && op_q == mid_pkg::OP_EXT_DECIMAL_ADJUST |-> acc_ff == acc_q &&
    flags_ff[mid_pkg::FLG_SC:mid_pkg::FLG_HALF] ==
    flg_q[mid_pkg::FLG_SC:mid_pkg::FLG_HALF])
    else $error("decimal adjust touched more than carry");
  AST_INC: assert property (
    take_q && op_q == mid_pkg::OP_EXT_INCREMENT_TO_ACC |->
    acc_ff == m_q + 8'h01 && flags_ff[mid_pkg::FLG_Z] == (acc_ff == 8'h00))
    else $error("increment to acc wrong");
  AST_MOVE: assert property (
    take_q && op_q == mid_pkg::OP_EXT_MOVE |-> acc_ff == m_q &&
    flags_ff == flg_q)
    else $error("move to acc wrong");
endmodule

/* File: testbench/mid_prog_model.sv */
// program memory model answering table fetches
`timescale 1ns/1ps
module mid_prog_model #(
  parameter int W = 12
) (
  input  wire logic         sys_clk,
  input  wire logic         prog_rd_ff,
  input  wire logic [W-1:0] prog_addr_ff,
  output logic      [15:0]  prog_rdata
);
  initial prog_rdata = 16'h3C5A;
  // word one cycle after the request, toggling junk otherwise
  always @(posedge sys_clk) begin
    if (prog_rd_ff)
      prog_rdata <= {prog_addr_ff[7:0] ^ 8'h5A, prog_addr_ff[W-1:W-8]};
    else
      prog_rdata <= ~prog_rdata;
  end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the instruction datapath
`timescale 1ns/1ps
module tb;
  logic                  sys_clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  cmd_valid = 1'b0;
  mid_pkg::mid_cmd_s     cmd = '0;
  mid_pkg::mid_reg_req_s reg_req = '0;
  logic [15:0]           prog_rdata;
  logic                  busy_ff, done_ff, skip_ff, prog_rd_ff;
  logic [7:0]            acc_ff, reg_rdata_ff;
  logic [4:0]            flags_ff;
  logic [11:0]           prog_addr_ff;
  int                    mismatches = 0;
  int                    total_checks = 0;
  logic [7:0]            q_rd[$];
  logic                  q_sk[$];
  logic                  rd_d = 1'b0;
  logic                  sk = 1'b0;
  logic [31:0]           rs = 32'h23973144;
  always #20 sys_clk = ~sys_clk;
  mid_datapath u_mid_datapath (.sys_clk(sys_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd(cmd), .prog_rdata(prog_rdata),
    .reg_req(reg_req), .busy_ff(busy_ff), .done_ff(done_ff),
    .skip_ff(skip_ff), .acc_ff(acc_ff), .flags_ff(flags_ff),
    .prog_addr_ff(prog_addr_ff), .prog_rd_ff(prog_rd_ff),
    .reg_rdata_ff(reg_rdata_ff));
  mid_prog_model u_mid_prog_model (.sys_clk(sys_clk),
    .prog_rd_ff(prog_rd_ff), .prog_addr_ff(prog_addr_ff),
    .prog_rdata(prog_rdata));
  function automatic logic [31:0] nx(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected {acc, byte, flags}
  function automatic logic [20:0] rf(logic [4:0] o, logic [7:0] a, m,
                                     logic [4:0] f, logic [2:0] b,
                                     logic [7:0] im);
    logic [8:0] s;
    logic [7:0] na, nm, r;
    logic [4:0] nf;
    logic       ci, lo, hi;
    na = a;
    nm = m;
    nf = f;
    r = m;
    ci = (o <= 5'h0D) ? f[0] : 1'b0;
    case (o)
      5'h01: r = {m[3:0], m[7:4]};
      5'h09, 5'h0A: r = a ^ m;
      5'h0B: r = a ^ im;
      5'h10, 5'h11: r = a & m;
      5'h14, 5'h15: r = ~m;
      5'h17, 5'h18: r = m - 8'h01;
      5'h19, 5'h1A: r = m + 8'h01;
      5'h1C: r = a;
      5'h12: r = 8'h00;
      5'h13: r[b] = 1'b0;
      5'h0C, 5'h0D, 5'h0E, 5'h0F: begin
        s = a + m + ci;
        r = s[7:0];
        nf[0] = s[8];
        nf[1] = ({1'b0, a[3:0]} + m[3:0] + ci) > 5'h0F;
        nf[3] = (a[7] == m[7]) && (r[7] != a[7]);
        nf[4] = nf[3] ^ r[7];
      end
      5'h16: begin
        lo = (a[3:0] > 4'h9) || f[1];
        hi = (a[7:4] > 4'h9) || f[0];
        s = a + {hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
        r = s[7:0];
        nf[0] = hi | s[8];
      end
      default: ;
    endcase
    if ((o >= 5'h09 && o <= 5'h11) || o inside {5'h14, 5'h15, [5'h17:5'h1A]})
      nf[2] = (r == 8'h00);
    if (o inside {5'h01, 5'h03, 5'h09, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h15,
                  5'h18, 5'h1A, 5'h1B}) na = r;
    else if (o > 5'h09) nm = r;
    return {na, nm, nf};
  endfunction
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rg(bit w, logic [2:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= {w, !w, a, d};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask
  task rd(logic [2:0] a, logic [7:0] e);
    q_rd.push_back(e);
    rg(1'b0, a, 8'h00);
  endtask
  task setm(logic [9:0] ad, logic [7:0] d);
    rg(1'b1, mid_pkg::REG_SECT, {6'h00, ad[9:8]});
    rg(1'b1, mid_pkg::REG_DM_PTR, ad[7:0]);
    rg(1'b1, mid_pkg::REG_DM_DATA, d);
  endtask
  task chkm(logic [9:0] ad, logic [7:0] e);
    rg(1'b1, mid_pkg::REG_SECT, {6'h00, ad[9:8]});
    rg(1'b1, mid_pkg::REG_DM_PTR, ad[7:0]);
    rd(mid_pkg::REG_DM_DATA, e);
  endtask
  task exec(int k, logic [9:0] ad, logic [2:0] b, logic [7:0] im,
            logic s, int lat);
    int n;
    n = 0;
    q_sk.push_back(s);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= '{mid_pkg::mid_op_e'(k[4:0]), b, ad, im};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
      if (n == 1) chk("busy", 16'(lat > 1), 16'(busy_ff));
    end while (n < 10 && done_ff !== 1'b1);
    chk("latency", 16'(lat), 16'(n));
  endtask
  // result watcher
  always @(posedge sys_clk) begin
    rd_d <= reg_req.rd;
    if (rd_d) chk("reg_rdata", q_rd.pop_front(), reg_rdata_ff);
    sk <= (done_ff === 1'b1) ? 1'b0 : (sk | (skip_ff === 1'b1));
    if (done_ff === 1'b1)
      chk("skip", q_sk.pop_front(), sk | (skip_ff === 1'b1));
  end
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #800000;
    mismatches++;
    final_report;
  end
  initial begin
    logic [9:0]  ad;
    logic [7:0]  a, m, lo, lo2;
    logic [11:0] pa;
    logic [15:0] w;
    logic [20:0] e;
    logic        s;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int k = 1; k <= 28; k++) begin
      if (k >= 5 && k <= 8) continue;
      for (int i = 0; i < 3; i++) begin
        rs = nx(rs);
        ad = rs[9:0];
        a = rs[17:10];
        m = (i > 0) ? rs[25:18] : (k < 5) ? 8'h00 : a;
        s = (k == 4) ? !m[rs[2:0]] : (k > 1 && k < 4 && m == 8'h00);
        setm(ad, m);
        rg(1'b1, mid_pkg::REG_ACC, a);
        rg(1'b1, mid_pkg::REG_STATUS, {3'h0, rs[30:26]});
        if (k >= 12) rg(1'b1, mid_pkg::REG_SECT, {6'h00, ~ad[9:8]});
        e = rf(k[4:0], a, m, rs[30:26], rs[2:0], rs[31:24]);
        exec(k, ad, rs[2:0], rs[31:24], s, s ? 2 : 1);
        chk("acc_ff", 16'(e[20:13]), 16'(acc_ff));
        chk("flags_ff", 16'(e[4:0]), 16'(flags_ff));
        rd(mid_pkg::REG_ACC, e[20:13]);
        rd(mid_pkg::REG_STATUS, {3'h0, e[4:0]});
        chkm(ad, e[12:5]);
      end
      $display("test op %0d done", k);
    end
    for (int k = 5; k <= 8; k++) begin
      for (int i = 0; i < 2; i++) begin
        rs = nx(rs);
        ad = rs[9:0];
        lo = (i > 0) ? 8'hFF : rs[17:10];
        lo2 = lo + ((k > 6) ? 8'h01 : 8'h00);
        pa = k[0] ? {rs[21:18], lo2} : {4'hF, lo2};
        w = {pa[7:0] ^ 8'h5A, pa[11:4]};
        rg(1'b1, mid_pkg::REG_TPTR_LO, lo);
        rg(1'b1, mid_pkg::REG_TPTR_HI, rs[25:18]);
        setm(ad, ~w[7:0]);
        exec(k, ad, 3'h0, 8'h00, 1'b0, 3);
        chkm(ad, w[7:0]);
        rd(mid_pkg::REG_THIGH, w[15:8]);
        rd(mid_pkg::REG_TPTR_LO, lo2);
        rg(1'b1, mid_pkg::REG_THIGH, ~w[15:8]);
        rd(mid_pkg::REG_THIGH, w[15:8]);
      end
      $display("test table op %0d done", k);
    end
    final_report;
  end
endmodule
